// File: hw/seb_map.svh
`ifndef SEB_MAP_SVH
`define SEB_MAP_SVH
`define SEB_TYPE_MAIN     4'hA
`define SEB_TYPE_IDPAGE   4'hB
`define SEB_RW_READ       1'h1
`define SEB_BITS_PER_BYTE 4'h8
`define SEB_ACK_SLOT      4'h9
`define SEB_ADDR_BYTES    2'h2
`define SEB_WRITE_TIME_NS 4000000
`define SEB_CLK_NS        10
`define SEB_WRITE_CYCLES  (`SEB_WRITE_TIME_NS / `SEB_CLK_NS)
`define SEB_LINK_DIV      6
`endif

// File: hw/seb_pkg.sv
package seb_pkg;
	typedef enum logic [5:0] {
		SEB_IDLE  = 6'h01,
		SEB_SEL   = 6'h02,
		SEB_ADDR  = 6'h04,
		SEB_DATA  = 6'h08,
		SEB_STBY  = 6'h10,
		SEB_WRITE = 6'h20
	} seb_state_t;
	typedef enum logic [4:0] {
		SEBM_IDLE  = 5'h01,
		SEBM_START = 5'h02,
		SEBM_BIT   = 5'h04,
		SEBM_STOP  = 5'h08,
		SEBM_DONE  = 5'h10
	} seb_mstate_t;
endpackage

// File: hw/seb_bus_if.sv
`timescale 1ns/1ps
interface seb_bus_if;
	logic scl_o;
	logic scl_oe_n;
	logic sda_m_o;
	logic sda_m_oe_n;
	logic sda_d_o;
	logic sda_d_oe_n;
	logic scl;
	logic sda;
	// open drain: any enabled low driver pulls the wire low
	assign scl = ~(~scl_oe_n & ~scl_o);
	assign sda = ~((~sda_m_oe_n & ~sda_m_o) | (~sda_d_oe_n & ~sda_d_o));
	modport device (input scl, input sda, output sda_d_o, output sda_d_oe_n);
	modport master (input scl, input sda, output scl_o, output scl_oe_n,
		output sda_m_o, output sda_m_oe_n);
endinterface

// File: hw/seb_sync.sv
`timescale 1ns/1ps
module seb_sync (
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic din,
	output logic      dout
);
	logic stage1;
	logic next_stage1;
	logic next_dout;
	always_comb begin
		next_stage1 = din;
		next_dout   = stage1;
	end
	// idle bus level is high
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stage1 <= 1'b1;
			dout   <= 1'b1;
		end else begin
			stage1 <= next_stage1;
			dout   <= next_dout;
		end
	end
endmodule

// File: hw/seb_device.sv
`timescale 1ns/1ps
// Function
// - sda falling with scl high is start
// - master starts every instruction with start
// - watch start always, except write cycle
// - sda rising with scl high stops
// - stop after write triggers write cycle
// - sample sda on scl rising edge
// - master changes sda for data and ack bits only while scl low
// - transmitter releases sda after eight bits
// - receiver pulls sda low in ninth pulse
// - accept only type 1010b or 1011b
// - select bits b3..b1 match chip selects
// - b0 one reads, zero writes
// - select byte sent msb first
// - matching select byte acknowledged
// - mismatch: standby until next start
// - two address bytes, high first, acknowledged
// - protect high: no data acknowledge, no write
// - protect low or open allows writes
// - open chip select reads as zero
// - device is target only
// - write only on stop after data ack
// - write cycle: sda released, bus ignored
`include "seb_map.svh"
module seb_device #(
	parameter int WRITE_CYCLES = `SEB_WRITE_CYCLES
) (
	input  wire logic  clk,
	input  wire logic  arst_n,
	seb_bus_if.device  bus,
	input  wire logic  [2:0] chip_select_pins,
	input  wire logic  write_protect_input,
	output logic       selected,
	output logic       id_page,
	output logic       read_mode,
	output logic [15:0] mem_addr,
	output logic       write_busy,
	output logic       write_start
);
	import seb_pkg::*;
	logic       scl_s;
	logic       sda_s;
	logic       scl_d;
	logic       sda_d;
	logic       wp_s;
	logic [2:0] cs_s;
	seb_state_t state;
	seb_state_t next_state;
	logic [3:0] bit_cnt;
	logic [3:0] next_bit_cnt;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic [1:0] addr_cnt;
	logic [1:0] next_addr_cnt;
	logic       ack_drv;
	logic       next_ack_drv;
	logic       data_acked;
	logic       next_data_acked;
	logic [31:0] wcnt;
	logic [31:0] next_wcnt;
	logic       next_selected;
	logic       next_id_page;
	logic       next_read_mode;
	logic [15:0] next_mem_addr;
	logic       next_write_start;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_cond;
	logic       stop_cond;
	logic [7:0] byte_in;
	logic       sel_ok;
	logic       data_ok;

	seb_sync u_scl (.clk(clk), .arst_n(arst_n), .din(bus.scl), .dout(scl_s));
	seb_sync u_sda (.clk(clk), .arst_n(arst_n), .din(bus.sda), .dout(sda_s));
	// pins are slow straps, synchronised all the same; open pins come as 0
	seb_sync u_wp (.clk(clk), .arst_n(arst_n), .din(write_protect_input),
		.dout(wp_s));
	seb_sync u_cs2 (.clk(clk), .arst_n(arst_n), .din(chip_select_pins[2]),
		.dout(cs_s[2]));
	seb_sync u_cs1 (.clk(clk), .arst_n(arst_n), .din(chip_select_pins[1]),
		.dout(cs_s[1]));
	seb_sync u_cs0 (.clk(clk), .arst_n(arst_n), .din(chip_select_pins[0]),
		.dout(cs_s[0]));

	always_comb begin
		scl_rise   = scl_s & ~scl_d;
		scl_fall   = ~scl_s & scl_d;
		start_cond = scl_s & scl_d & sda_d & ~sda_s;
		stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
		byte_in    = {shreg[6:0], sda_s};
		// judged on bits b7..b1 of the byte, held from the eighth clock fall
		sel_ok     = (shreg[7:4] == `SEB_TYPE_MAIN ||
			shreg[7:4] == `SEB_TYPE_IDPAGE) &&
			(shreg[3:1] == cs_s);
		data_ok    = ~wp_s;
	end

	always_comb begin
		next_state       = state;
		next_bit_cnt     = bit_cnt;
		next_shreg       = shreg;
		next_addr_cnt    = addr_cnt;
		next_ack_drv     = ack_drv;
		next_data_acked  = data_acked;
		next_wcnt        = wcnt;
		next_selected    = selected;
		next_id_page     = id_page;
		next_read_mode   = read_mode;
		next_mem_addr    = mem_addr;
		next_write_start = 1'b0;
		case (state)
		SEB_WRITE: begin
			// bus ignored entirely until the cycle ends
			next_ack_drv = 1'b0;
			if (wcnt == 32'h0000_0001) begin
				next_state = SEB_IDLE;
				next_wcnt  = 32'h0000_0000;
			end else begin
				next_wcnt = wcnt - 32'h0000_0001;
			end
		end
		default: begin
			if (start_cond) begin
				next_state      = SEB_SEL;
				next_bit_cnt    = 4'h0;
				next_ack_drv    = 1'b0;
				next_data_acked = 1'b0;
				next_selected   = 1'b0;
			end else if (stop_cond) begin
				next_ack_drv  = 1'b0;
				next_selected = 1'b0;
				// stop must sit in the slot right after an acked data byte
				if (state == SEB_DATA && data_acked && bit_cnt == 4'h1 &&
						data_ok) begin
					next_state       = SEB_WRITE;
					next_wcnt        = 32'(WRITE_CYCLES);
					next_write_start = 1'b1;
				end else begin
					next_state = SEB_IDLE;
				end
			end else if (state == SEB_SEL || state == SEB_ADDR ||
					state == SEB_DATA) begin
				if (scl_rise) begin
					if (bit_cnt < `SEB_BITS_PER_BYTE)
						next_shreg = byte_in;
					next_bit_cnt = bit_cnt + 4'h1;
					// flag survives the tenth slot rise that precedes a stop
					if (bit_cnt != 4'h8 && bit_cnt != 4'h0)
						next_data_acked = 1'b0;
				end else if (scl_fall) begin
					if (bit_cnt == `SEB_BITS_PER_BYTE) begin
						// byte complete: decide ack for ninth pulse
						case (state)
						SEB_SEL: begin
							if (sel_ok) begin
								next_ack_drv   = 1'b1;
								next_selected  = 1'b1;
								next_id_page   = shreg[4];
								next_read_mode = shreg[0] == `SEB_RW_READ;
							end else begin
								next_state = SEB_STBY;
							end
						end
						SEB_ADDR: begin
							next_ack_drv = 1'b1;
							if (addr_cnt == 2'h0)
								next_mem_addr = {shreg, mem_addr[7:0]};
							else
								next_mem_addr = {mem_addr[15:8], shreg};
							next_addr_cnt = addr_cnt + 2'h1;
						end
						default: begin
							next_ack_drv    = data_ok;
							next_data_acked = data_ok;
						end
						endcase
					end else if (bit_cnt == `SEB_ACK_SLOT) begin
						next_ack_drv = 1'b0;
						next_bit_cnt = 4'h0;
						if (state == SEB_SEL) begin
							next_state    = read_mode ? SEB_STBY : SEB_ADDR;
							next_addr_cnt = 2'h0;
						end else if (state == SEB_ADDR &&
								addr_cnt == `SEB_ADDR_BYTES) begin
							next_state = SEB_DATA;
						end
					end
				end
			end
		end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_d       <= 1'b1;
			sda_d       <= 1'b1;
			state       <= SEB_IDLE;
			bit_cnt     <= 4'h0;
			shreg       <= 8'h00;
			addr_cnt    <= 2'h0;
			ack_drv     <= 1'b0;
			data_acked  <= 1'b0;
			wcnt        <= 32'h0000_0000;
			selected    <= 1'b0;
			id_page     <= 1'b0;
			read_mode   <= 1'b0;
			mem_addr    <= 16'h0000;
			write_start <= 1'b0;
		end else begin
			scl_d       <= scl_s;
			sda_d       <= sda_s;
			state       <= next_state;
			bit_cnt     <= next_bit_cnt;
			shreg       <= next_shreg;
			addr_cnt    <= next_addr_cnt;
			ack_drv     <= next_ack_drv;
			data_acked  <= next_data_acked;
			wcnt        <= next_wcnt;
			selected    <= next_selected;
			id_page     <= next_id_page;
			read_mode   <= next_read_mode;
			mem_addr    <= next_mem_addr;
			write_start <= next_write_start;
		end
	end

	// target only: never drives scl, only pulls sda for acks
	always_comb begin
		bus.sda_d_o    = 1'b0;
		bus.sda_d_oe_n = ~ack_drv;
		write_busy     = (state == SEB_WRITE);
	end
endmodule

// File: hw/seb_master.sv
`timescale 1ns/1ps
`include "seb_map.svh"
module seb_master #(
	parameter int DIV = `SEB_LINK_DIV
) (
	input  wire logic  clk,
	input  wire logic  arst_n,
	seb_bus_if.master  bus,
	input  wire logic  req,
	input  wire logic  [7:0] wr_byte,
	input  wire logic  last,
	output logic       busy,
	output logic       byte_done,
	output logic       acked
);
	import seb_pkg::*;
	seb_mstate_t state;
	seb_mstate_t next_state;
	logic [15:0] div_cnt;
	logic [15:0] next_div_cnt;
	logic [1:0]  phase;
	logic [1:0]  next_phase;
	logic [3:0]  bit_cnt;
	logic [3:0]  next_bit_cnt;
	logic [7:0]  shreg;
	logic [7:0]  next_shreg;
	logic        scl_q;
	logic        next_scl_q;
	logic        sda_q;
	logic        next_sda_q;
	logic        next_byte_done;
	logic        next_acked;
	logic        last_q;
	logic        next_last_q;
	logic        tick;
	logic        sda_s;

	// sda is an asynchronous wire-and with the device
	seb_sync u_sda (.clk(clk), .arst_n(arst_n), .din(bus.sda), .dout(sda_s));

	always_comb begin
		tick = (div_cnt == 16'(DIV - 1));
		next_div_cnt = tick ? 16'h0000 : div_cnt + 16'h0001;
	end

	always_comb begin
		next_state     = state;
		next_phase     = phase;
		next_bit_cnt   = bit_cnt;
		next_shreg     = shreg;
		next_scl_q     = scl_q;
		next_sda_q     = sda_q;
		next_byte_done = 1'b0;
		next_acked     = acked;
		next_last_q    = last_q;
		case (state)
		SEBM_IDLE: begin
			if (req) begin
				next_state  = SEBM_START;
				next_shreg  = wr_byte;
				next_last_q = last;
				next_phase  = 2'h0;
			end
		end
		SEBM_START: if (tick) begin
			next_sda_q   = 1'b0;
			next_state   = SEBM_BIT;
			next_bit_cnt = 4'h0;
			next_phase   = 2'h0;
		end
		SEBM_BIT: if (tick) begin
			next_phase = phase + 2'h1;
			case (phase)
			2'h0: begin
				next_scl_q = 1'b0;
			end
			2'h1: begin
				// data changes only while scl low; ack slot released
				next_sda_q = (bit_cnt < `SEB_BITS_PER_BYTE) ?
					shreg[7] : 1'b1;
			end
			2'h2: next_scl_q = 1'b1;
			default: begin
				if (bit_cnt == `SEB_BITS_PER_BYTE) begin
					next_acked     = ~sda_s;
					next_byte_done = 1'b1;
					next_bit_cnt   = 4'h0;
					if (last_q || sda_s)
						next_state = SEBM_STOP;
					else
						next_state = SEBM_DONE;
				end else begin
					next_shreg   = {shreg[6:0], 1'b0};
					next_bit_cnt = bit_cnt + 4'h1;
				end
			end
			endcase
		end
		SEBM_DONE: begin
			if (req) begin
				next_shreg  = wr_byte;
				next_last_q = last;
				next_state  = SEBM_BIT;
				next_phase  = 2'h0;
			end
		end
		SEBM_STOP: if (tick) begin
			next_phase = phase + 2'h1;
			case (phase)
			2'h0: next_scl_q = 1'b0;
			2'h1: next_sda_q = 1'b0;
			2'h2: next_scl_q = 1'b1;
			default: begin
				next_sda_q = 1'b1;
				next_state = SEBM_IDLE;
			end
			endcase
		end
		default: next_state = SEBM_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state     <= SEBM_IDLE;
			div_cnt   <= 16'h0000;
			phase     <= 2'h0;
			bit_cnt   <= 4'h0;
			shreg     <= 8'h00;
			scl_q     <= 1'b1;
			sda_q     <= 1'b1;
			byte_done <= 1'b0;
			acked     <= 1'b0;
			last_q    <= 1'b0;
		end else begin
			state     <= next_state;
			div_cnt   <= next_div_cnt;
			phase     <= next_phase;
			bit_cnt   <= next_bit_cnt;
			shreg     <= next_shreg;
			scl_q     <= next_scl_q;
			sda_q     <= next_sda_q;
			byte_done <= next_byte_done;
			acked     <= next_acked;
			last_q    <= next_last_q;
		end
	end

	// open drain: enable only to pull low
	always_comb begin
		bus.scl_o      = 1'b0;
		bus.scl_oe_n   = scl_q;
		bus.sda_m_o    = 1'b0;
		bus.sda_m_oe_n = sda_q;
		busy           = (state != SEBM_IDLE) && (state != SEBM_DONE);
	end
endmodule

// File: test/seb_link_asserts.sv
`timescale 1ns/1ps
module seb_link_asserts (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_d_o,
	input wire logic sda_d_oe_n,
	input wire logic selected,
	input wire logic write_busy,
	input wire logic write_start
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// open drain: an enabled device driver may only pull low
	property p_drive_low;
		!sda_d_oe_n |-> !sda_d_o;
	endproperty
	a_drive_low: assert property (p_drive_low)
		else $error("device drives sda high");
	// ack edges must fall in the low phase, never on a high clock
	property p_ack_steady;
		$changed(sda_d_oe_n) |-> !scl;
	endproperty
	a_ack_steady: assert property (p_ack_steady)
		else $error("device sda drive changed while scl high");
	property p_stop_clear;
		($rose(sda) && scl) |-> ##[1:8] !selected;
	endproperty
	a_stop_clear: assert property (p_stop_clear)
		else $error("selection kept after stop");
	property p_start_clear;
		($fell(sda) && scl) |-> ##[1:8] !selected;
	endproperty
	a_start_clear: assert property (p_start_clear)
		else $error("selection kept after start");
	property p_busy_quiet;
		write_busy |-> sda_d_oe_n;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet)
		else $error("sda driven during write cycle");
	property p_busy_unsel;
		write_busy |-> !selected;
	endproperty
	a_busy_unsel: assert property (p_busy_unsel)
		else $error("device selected during write cycle");
	property p_start_busy;
		write_start |-> ##1 write_busy;
	endproperty
	a_start_busy: assert property (p_start_busy)
		else $error("write start without busy");
	property p_write_idle;
		write_start |-> scl && sda;
	endproperty
	a_write_idle: assert property (p_write_idle)
		else $error("write started on a non idle bus");
	property p_write_len;
		$rose(write_busy) |-> write_busy[*8];
	endproperty
	a_write_len: assert property (p_write_len)
		else $error("write cycle too short");
endmodule

// File: test/serial_eeprom_bus_front_end_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin \
	$display("unexpected %s exp %0h got %0h", nm, e, a); \
	miscompares++; end end
module serial_eeprom_bus_front_end_tb;
	import seb_pkg::*;
	localparam int WCYC = 600;
	logic        clk;
	logic        arst_n = 1'b0;
	logic        req = 1'b0;
	logic        last = 1'b0;
	logic        wp = 1'b0;
	logic [7:0]  wr_byte = 8'h00;
	logic [2:0]  cs = 3'h5;
	logic        busy;
	logic        byte_done;
	logic        acked;
	logic        selected;
	logic        id_page;
	logic        read_mode;
	logic        write_busy;
	logic        write_start;
	logic [15:0] mem_addr;
	logic [8:0]  shreg = 9'h000;
	logic [3:0]  ty [4] = '{4'h2, 4'hA, 4'hB, 4'hD};
	int          miscompares = 0;
	int          tests_run = 0;
	int          writes = 0;
	logic        hit;
	int          i;
	int          n;

	seb_bus_if bif ();
	seb_master #(.DIV(6)) seb_master_i (.clk(clk), .arst_n(arst_n),
		.bus(bif.master), .req(req), .wr_byte(wr_byte), .last(last),
		.busy(busy), .byte_done(byte_done), .acked(acked));
	// short write cycle keeps the run brief yet outlasts one select byte
	seb_device #(.WRITE_CYCLES(WCYC)) seb_device_i (.clk(clk),
		.arst_n(arst_n), .bus(bif.device), .chip_select_pins(cs),
		.write_protect_input(wp), .selected(selected), .id_page(id_page),
		.read_mode(read_mode), .mem_addr(mem_addr),
		.write_busy(write_busy), .write_start(write_start));
	seb_link_asserts seb_link_asserts_i (.clk(clk), .arst_n(arst_n),
		.scl(bif.scl), .sda(bif.sda), .sda_d_o(bif.sda_d_o),
		.sda_d_oe_n(bif.sda_d_oe_n), .selected(selected),
		.write_busy(write_busy), .write_start(write_start));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// wire view: nine bits per byte, ack slot last
	always @(posedge bif.scl) shreg <= {shreg[7:0], bif.sda};
	always @(posedge clk) if (write_start === 1'b1) writes++;

	task give_verdict;
		begin
			$display("checks %0d mismatches %0d", tests_run, miscompares);
			if (miscompares == 0 && tests_run > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask

	task tick;
		begin
			@(posedge clk);
			#1;
		end
	endtask

	task tx(input logic [7:0] b, input logic l, input logic e);
		begin
			tick();
			wr_byte = b;
			last = l;
			req = 1'b1;
			tick();
			req = 1'b0;
			n = 0;
			while (byte_done !== 1'b1 && n < 4000) begin
				tick();
				n++;
			end
			`CHK("done", 1'b1, byte_done)
			`CHK("ack", e, acked)
			`CHK("wire", {b, ~e}, shreg)
			if (l || !e) begin
				n = 0;
				while (busy !== 1'b0 && n < 400) begin
					tick();
					n++;
				end
				// synchronisers need a few cycles to see the stop
				repeat (8) tick();
				`CHK("busy", 1'b0, busy)
				`CHK("idle", 2'h3, {bif.scl, bif.sda})
				`CHK("sel", 1'b0, selected)
			end
		end
	endtask

	initial begin
		repeat (16) @(posedge clk);
		#1 arst_n = 1'b1;
		repeat (4) tick();
		tx(8'hAA, 1'b0, 1'b1);
		tx(8'h12, 1'b0, 1'b1);
		tx(8'h34, 1'b0, 1'b1);
		`CHK("addr", 16'h1234, mem_addr)
		`CHK("rw", 1'b0, read_mode)
		tx(8'h5A, 1'b1, 1'b1);
		`CHK("writes", 1, writes)
		`CHK("wbusy", 1'b1, write_busy)
		tx(8'hAA, 1'b1, 1'b0);
		n = 0;
		while (write_busy !== 1'b0 && n < 2 * WCYC) begin
			tick();
			n++;
		end
		`CHK("wend", 1'b0, write_busy)
		for (i = 0; i < 4; i++) begin
			hit = (ty[i] == 4'hA) || (ty[i] == 4'hB);
			tx({ty[i], 3'h5, 1'b0}, 1'b0, hit);
			if (hit) begin
				`CHK("idp", ty[i][0], id_page)
				`CHK("sel", 1'b1, selected)
				tx(8'h00, 1'b1, 1'b1);
			end
		end
		for (i = 0; i < 8; i++)
			tx({4'hA, i[2:0], 1'b0}, 1'b1, i == 5);
		tx(8'hAB, 1'b0, 1'b1);
		`CHK("rw", 1'b1, read_mode)
		tx(8'hFF, 1'b1, 1'b0);
		cs = 3'h2;
		tx(8'hA4, 1'b1, 1'b1);
		tx(8'hAA, 1'b1, 1'b0);
		cs = 3'h5;
		wp = 1'b1;
		tx(8'hAA, 1'b0, 1'b1);
		tx(8'h00, 1'b0, 1'b1);
		tx(8'h01, 1'b0, 1'b1);
		tx(8'h77, 1'b1, 1'b0);
		`CHK("writes", 1, writes)
		give_verdict();
	end

	initial begin
		#400000;
		miscompares++;
		give_verdict();
	end
endmodule
